// File: dic_pkg.sv
// Shared constants for the digital input conditioning and relay drive block.
package dic_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_INPUTS = 3;
    localparam int NUM_RELAYS = 5;
    localparam int DELAY_W = 21;
    localparam int SEL_W = 2;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 200_000_000;
    localparam int MS_PER_SEC = 1000;
    localparam int MS_CYCLES = CLK_HZ / MS_PER_SEC;
    localparam int SCAN_PERIOD_MS = 5;
    localparam int OUT_SCAN_MS = 5;
    localparam logic [DELAY_W-1:0] AC_EXTRA_MS = 21'h00001E;
    localparam logic [DELAY_W-1:0] DELAY_RESET = 21'h000000;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_INPUT_CFG = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_RELAY_SW = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_ROUTE_EN = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_ROUTE_SEL = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_PICKUP_BASE = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_DROPOUT_BASE = 8'h1C;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h28;
    localparam logic [ADDR_W-1:0] OFF_FAULT_CTRL = 8'h2C;
    localparam logic [ADDR_W-1:0] REG_STRIDE = 8'h04;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CFG_INVERT_LSB = 0;
    localparam int CFG_AC_LSB = 8;
    localparam int STAT_REPORTED_LSB = 0;
    localparam int STAT_CONSUMER_LSB = 4;
    localparam int STAT_RAW_LSB = 8;
    localparam int STAT_RELAY_LSB = 16;
    localparam int STAT_FAULT_RELAY_BIT = 24;
    localparam int FAULT_FORCE_BIT = 0;

    // Byte address of the idx-th word of a register array.
    function automatic logic [ADDR_W-1:0] regOffset(input logic [ADDR_W-1:0] base,
                                                    input int idx);
        regOffset = base + ADDR_W'(idx) * REG_STRIDE;
    endfunction

endpackage

// File: scan_timer.sv
// Millisecond tick and periodic scan tick generator.
`timescale 1ns/1ps
module scan_timer
    import dic_pkg::*;
#(
    parameter int MS_CYCLES_P = MS_CYCLES,
    parameter int SCAN_MS_P = SCAN_PERIOD_MS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Ticks
    output logic msTick,
    output logic scanTick
);

    typedef struct packed {
        logic [31:0] cycleCnt;
        logic [7:0] msCnt;
        logic msTick;
        logic scanTick;
    } timer_state_t;

    timer_state_t state_reg;
    timer_state_t state_next;

    always_comb begin
        state_next = state_reg;
        state_next.msTick = 1'b0;
        state_next.scanTick = 1'b0;
        if (state_reg.cycleCnt == 32'(MS_CYCLES_P - 1)) begin
            state_next.cycleCnt = '0;
            state_next.msTick = 1'b1;
            if (state_reg.msCnt == 8'(SCAN_MS_P - 1)) begin
                state_next.msCnt = '0;
                state_next.scanTick = 1'b1;
            end else begin
                state_next.msCnt = state_reg.msCnt + 8'h01;
            end
        end else begin
            state_next.cycleCnt = state_reg.cycleCnt + 32'h00000001;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign msTick = state_reg.msTick;
    assign scanTick = state_reg.scanTick;

endmodule

// File: input_conditioner.sv
// One input channel: scan sampling, polarity select, pick-up and drop-off delays.
`timescale 1ns/1ps
module input_conditioner
    import dic_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Ticks
    input wire logic msTick,
    input wire logic scanTick,
    // Pin and settings
    input wire logic pinLevel,
    input wire logic invertSel,
    input wire logic acMode,
    input wire logic [DELAY_W-1:0] pickupDelay,
    input wire logic [DELAY_W-1:0] dropoutDelay,
    // Results
    output logic sampledLevel,
    output logic reportedLevel
);

    typedef struct packed {
        logic sampled;
        logic reported;
        logic [DELAY_W:0] count;
    } chan_state_t;

    chan_state_t state_reg;
    chan_state_t state_next;
    logic [DELAY_W:0] limit;

    always_comb begin
        state_next = state_reg;
        limit = {1'b0, pickupDelay};
        if (state_reg.reported) begin
            limit = {1'b0, dropoutDelay} + {1'b0, (acMode ? AC_EXTRA_MS : DELAY_RESET)};
        end
        if (scanTick) begin
            state_next.sampled = pinLevel ^ invertSel;
        end
        if (state_reg.sampled == state_reg.reported) begin
            state_next.count = '0;
        end else if (state_reg.count >= limit) begin
            state_next.reported = state_reg.sampled;
            state_next.count = '0;
        end else if (msTick) begin
            state_next.count = state_reg.count + 22'h000001;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sampledLevel = state_reg.sampled;
    assign reportedLevel = state_reg.reported;

endmodule

// File: digital_input_conditioning.sv
// Top level: input conditioning, register port, relay drive and system-fault relay.
`timescale 1ns/1ps
module digital_input_conditioning
    import dic_pkg::*;
#(
    parameter int MS_CYCLES_P = MS_CYCLES,
    parameter int SCAN_MS_P = SCAN_PERIOD_MS,
    parameter int OUT_SCAN_MS_P = OUT_SCAN_MS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Field inputs and health
    input wire logic [NUM_INPUTS-1:0] inputChannel,
    input wire logic powerGood,
    input wire logic systemFault,
    // Register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [DATA_W-1:0] regRdata,
    // Relay outputs and internal consumer view
    output logic [NUM_RELAYS-1:0] relayChannel,
    output logic faultRelayEnergize,
    output logic [NUM_INPUTS-1:0] inputState
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NUM_INPUTS-1:0] invertSel;
        logic [NUM_INPUTS-1:0] acMode;
        logic [NUM_INPUTS-1:0][DELAY_W-1:0] pickupDelay;
        logic [NUM_INPUTS-1:0][DELAY_W-1:0] dropoutDelay;
        logic [NUM_RELAYS-1:0] relaySw;
        logic [NUM_RELAYS-1:0] routeEn;
        logic [NUM_RELAYS-1:0][SEL_W-1:0] routeSel;
        logic faultForce;
        logic [NUM_INPUTS-1:0] consumerView;
        logic [NUM_RELAYS-1:0] relayDrive;
        logic faultRelay;
        logic [DATA_W-1:0] rdata;
    } top_state_t;

    top_state_t state_reg;
    top_state_t state_next;

    logic msTick;
    logic scanTick;
    logic outMsTick;
    logic outScanTick;
    logic [NUM_INPUTS-1:0] sampledLevel;
    logic [NUM_INPUTS-1:0] reportedLevel;

    // ------------------------------------------------------------------
    // Scan timing
    // ------------------------------------------------------------------
    scan_timer #(
        .MS_CYCLES_P(MS_CYCLES_P),
        .SCAN_MS_P(SCAN_MS_P)
    ) inputTimer (
        .mclk(mclk),
        .resetn(resetn),
        .msTick(msTick),
        .scanTick(scanTick)
    );

    // The output round has its own timer so its period can be set apart.
    scan_timer #(
        .MS_CYCLES_P(MS_CYCLES_P),
        .SCAN_MS_P(OUT_SCAN_MS_P)
    ) outputTimer (
        .mclk(mclk),
        .resetn(resetn),
        .msTick(outMsTick),
        .scanTick(outScanTick)
    );

    // ------------------------------------------------------------------
    // Input channels
    // ------------------------------------------------------------------
    for (genvar i = 0; i < NUM_INPUTS; i++) begin : gChan
        input_conditioner chan (
            .mclk(mclk),
            .resetn(resetn),
            .msTick(msTick),
            .scanTick(scanTick),
            .pinLevel(inputChannel[i]),
            .invertSel(state_reg.invertSel[i]),
            .acMode(state_reg.acMode[i]),
            .pickupDelay(state_reg.pickupDelay[i]),
            .dropoutDelay(state_reg.dropoutDelay[i]),
            .sampledLevel(sampledLevel[i]),
            .reportedLevel(reportedLevel[i])
        );
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.rdata = '0;

        // Register writes.
        if (regWrite) begin
            if (regAddr == OFF_INPUT_CFG) begin
                state_next.invertSel = regWdata[CFG_INVERT_LSB +: NUM_INPUTS];
                state_next.acMode = regWdata[CFG_AC_LSB +: NUM_INPUTS];
            end
            if (regAddr == OFF_RELAY_SW) begin
                state_next.relaySw = regWdata[NUM_RELAYS-1:0];
            end
            if (regAddr == OFF_ROUTE_EN) begin
                state_next.routeEn = regWdata[NUM_RELAYS-1:0];
            end
            if (regAddr == OFF_ROUTE_SEL) begin
                state_next.routeSel = regWdata[NUM_RELAYS*SEL_W-1:0];
            end
            if (regAddr == OFF_FAULT_CTRL) begin
                state_next.faultForce = regWdata[FAULT_FORCE_BIT];
            end
            for (int i = 0; i < NUM_INPUTS; i++) begin
                if (regAddr == regOffset(OFF_PICKUP_BASE, i)) begin
                    state_next.pickupDelay[i] = regWdata[DELAY_W-1:0];
                end
                if (regAddr == regOffset(OFF_DROPOUT_BASE, i)) begin
                    state_next.dropoutDelay[i] = regWdata[DELAY_W-1:0];
                end
            end
        end

        // Register reads; the data stand only in the following cycle.
        if (regRead) begin
            if (regAddr == OFF_INPUT_CFG) begin
                state_next.rdata[CFG_INVERT_LSB +: NUM_INPUTS] = state_reg.invertSel;
                state_next.rdata[CFG_AC_LSB +: NUM_INPUTS] = state_reg.acMode;
            end
            if (regAddr == OFF_RELAY_SW) begin
                state_next.rdata[NUM_RELAYS-1:0] = state_reg.relaySw;
            end
            if (regAddr == OFF_ROUTE_EN) begin
                state_next.rdata[NUM_RELAYS-1:0] = state_reg.routeEn;
            end
            if (regAddr == OFF_ROUTE_SEL) begin
                state_next.rdata[NUM_RELAYS*SEL_W-1:0] = state_reg.routeSel;
            end
            if (regAddr == OFF_FAULT_CTRL) begin
                state_next.rdata[FAULT_FORCE_BIT] = state_reg.faultForce;
            end
            if (regAddr == OFF_STATUS) begin
                state_next.rdata[STAT_REPORTED_LSB +: NUM_INPUTS] = reportedLevel;
                state_next.rdata[STAT_CONSUMER_LSB +: NUM_INPUTS] = state_reg.consumerView;
                state_next.rdata[STAT_RAW_LSB +: NUM_INPUTS] = sampledLevel;
                state_next.rdata[STAT_RELAY_LSB +: NUM_RELAYS] = state_reg.relayDrive;
                state_next.rdata[STAT_FAULT_RELAY_BIT] = state_reg.faultRelay;
            end
            for (int i = 0; i < NUM_INPUTS; i++) begin
                if (regAddr == regOffset(OFF_PICKUP_BASE, i)) begin
                    state_next.rdata[DELAY_W-1:0] = state_reg.pickupDelay[i];
                end
                if (regAddr == regOffset(OFF_DROPOUT_BASE, i)) begin
                    state_next.rdata[DELAY_W-1:0] = state_reg.dropoutDelay[i];
                end
            end
        end

        // Internal consumers take the conditioned state at the next scan.
        if (scanTick) begin
            state_next.consumerView = reportedLevel;
        end

        // Relays are refreshed on the output round; routed inputs come from
        // the consumer view (inputState), which takes the conditioned state only at each input scan.
        if (outScanTick) begin
            for (int r = 0; r < NUM_RELAYS; r++) begin
                if (state_reg.routeEn[r]) begin
                    if (int'(state_reg.routeSel[r]) < NUM_INPUTS) begin
                        state_next.relayDrive[r] =
                            state_reg.consumerView[state_reg.routeSel[r]];
                    end else begin
                        state_next.relayDrive[r] = 1'b0;
                    end
                end else begin
                    state_next.relayDrive[r] = state_reg.relaySw[r];
                end
            end
        end

        // The changeover relay drops whenever health is lost.
        state_next.faultRelay = powerGood & ~systemFault & ~state_reg.faultForce;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign regRdata = state_reg.rdata;
    assign relayChannel = state_reg.relayDrive;
    assign faultRelayEnergize = state_reg.faultRelay;
    assign inputState = state_reg.consumerView;

endmodule

// File: digital_input_conditioning_assertions.sv
// Port-level checks for the input conditioning and relay drive block.
`timescale 1ns/1ps
module digital_input_conditioning_assertions
    import dic_pkg::*;
#(
    parameter int MS_CYCLES_P = MS_CYCLES,
    parameter int SCAN_MS_P = SCAN_PERIOD_MS,
    parameter int OUT_SCAN_MS_P = OUT_SCAN_MS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Field inputs and health
    input wire logic [NUM_INPUTS-1:0] inputChannel,
    input wire logic powerGood,
    input wire logic systemFault,
    // Register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [DATA_W-1:0] regRdata,
    // Outputs
    input wire logic [NUM_RELAYS-1:0] relayChannel,
    input wire logic faultRelayEnergize,
    input wire logic [NUM_INPUTS-1:0] inputState
);
    // ------------------------------------------------------------------
    // Cycles since the last change of each scanned output
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    int relayGap;
    int stateGap;
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            relayGap <= 1000;
            stateGap <= 1000;
        end else begin
            relayGap <= $changed(relayChannel) ? 0 : (relayGap < 1000 ? relayGap + 1 : relayGap);
            stateGap <= $changed(inputState) ? 0 : (stateGap < 1000 ? stateGap + 1 : stateGap);
        end
    end
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    chk_relay_scan_period: assert property (
        $changed(relayChannel) |-> relayGap >= OUT_SCAN_MS_P * MS_CYCLES_P - 1)
        else $error("relay drive changed between output scans");
    chk_state_scan_period: assert property (
        $changed(inputState) |-> stateGap >= SCAN_MS_P * MS_CYCLES_P - 1)
        else $error("input state changed between scans");
    chk_fault_release: assert property (
        (systemFault || !powerGood) |=> !faultRelayEnergize)
        else $error("fault relay held during fault or power loss");
    chk_fault_rise_cause: assert property (
        $rose(faultRelayEnergize) |-> $past(powerGood && !systemFault))
        else $error("fault relay energized without healthy cause");
    chk_stat_fault_bit: assert property (
        regRead && regAddr == OFF_STATUS |=>
            regRdata[STAT_FAULT_RELAY_BIT] == $past(faultRelayEnergize))
        else $error("status fault relay bit wrong");
    chk_stat_relay_field: assert property (
        regRead && regAddr == OFF_STATUS |=>
            regRdata[STAT_RELAY_LSB +: NUM_RELAYS] == $past(relayChannel))
        else $error("status relay field wrong");
    chk_stat_state_field: assert property (
        regRead && regAddr == OFF_STATUS |=>
            regRdata[STAT_CONSUMER_LSB +: NUM_INPUTS] == $past(inputState))
        else $error("status consumer field wrong");
    chk_rdata_idle_zero: assert property (
        !$past(regRead) |-> regRdata == 32'h00000000)
        else $error("read data not zero outside read answer");
    cov_relay_change: cover property ($changed(relayChannel));
    cov_state_change: cover property ($changed(inputState));
    cov_fault_drop: cover property ($fell(faultRelayEnergize));
endmodule

bind digital_input_conditioning digital_input_conditioning_assertions #(
    .MS_CYCLES_P(MS_CYCLES_P),
    .SCAN_MS_P(SCAN_MS_P),
    .OUT_SCAN_MS_P(OUT_SCAN_MS_P)
) i_chk (
    .mclk(mclk), .resetn(resetn), .inputChannel(inputChannel), .powerGood(powerGood),
    .systemFault(systemFault), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .relayChannel(relayChannel),
    .faultRelayEnergize(faultRelayEnergize), .inputState(inputState)
);

// File: tb_digital_input_conditioning.sv
// Self-checking bench for the input conditioning and relay drive block.
`timescale 1ns/1ps
module tb_digital_input_conditioning
    import dic_pkg::*;
;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [NUM_INPUTS-1:0] inputChannel = 3'h0;
    logic powerGood = 1'b1;
    logic systemFault = 1'b0;
    logic [ADDR_W-1:0] regAddr = 8'h00;
    logic [DATA_W-1:0] regWdata = 32'h00000000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [DATA_W-1:0] regRdata;
    logic [NUM_RELAYS-1:0] relayChannel;
    logic faultRelayEnergize;
    logic [NUM_INPUTS-1:0] inputState;
    logic [DATA_W-1:0] rd;
    int badCount = 0;
    int checked = 0;

    // One millisecond is 4 cycles, so one scan is 20 cycles.
    digital_input_conditioning #(.MS_CYCLES_P(4), .SCAN_MS_P(5), .OUT_SCAN_MS_P(5)) i_dut (
        .mclk(mclk), .resetn(resetn), .inputChannel(inputChannel), .powerGood(powerGood),
        .systemFault(systemFault), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .relayChannel(relayChannel), .faultRelayEnergize(faultRelayEnergize),
        .inputState(inputState)
    );

    initial begin
        forever #2.5 mclk = ~mclk;
    end

    // ------------------------------------------------------------------
    // Bus, compare and wait tasks
    // ------------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            badCount++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a);
        @(posedge mclk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRead <= 1'b0;
        #1;
        rd = regRdata;
    endtask

    task automatic set_pins(input logic [2:0] v);
        @(posedge mclk);
        inputChannel <= v;
    endtask

    task automatic set_health(input logic pg, input logic sf);
        @(posedge mclk);
        powerGood <= pg;
        systemFault <= sf;
    endtask

    // Which: 0 input state, 1 relay drive, 2 fault relay.
    task automatic wait_for(input int which, input logic [7:0] exp, input int bound);
        logic [7:0] cur;
        cur = 8'h00;
        for (int n = 0; n < bound; n++) begin
            @(posedge mclk);
            #1;
            cur = which == 0 ? 8'(inputState) : which == 1 ? 8'(relayChannel)
                : 8'(faultRelayEnergize);
            if (cur === exp) break;
        end
        check("wait", 32'(exp), 32'(cur));
        if (cur !== exp) finish_test();
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_defaults();
        reg_read(OFF_INPUT_CFG);
        check("cfg", 32'h00000000, rd);
        for (int i = 0; i < 3; i++) begin
            reg_read(OFF_PICKUP_BASE + 8'(4 * i));
            check("pickup", 32'h00000000, rd);
            reg_read(OFF_DROPOUT_BASE + 8'(4 * i));
            check("dropout", 32'h00000000, rd);
        end
        reg_read(8'h30);
        check("unmapped", 32'h00000000, rd);
        check("fault relay", 32'h00000001, 32'(faultRelayEnergize));
    endtask

    task automatic test_polarity();
        set_pins(3'h5);
        wait_for(0, 8'h05, 45);
        reg_read(OFF_STATUS);
        check("sampled", 32'h5, 32'(rd[10:8]));
        reg_write(OFF_INPUT_CFG, 32'h00000007);
        wait_for(0, 8'h02, 45);
        reg_read(OFF_STATUS);
        check("sampled inv", 32'h2, 32'(rd[10:8]));
        reg_write(OFF_INPUT_CFG, 32'h00000000);
        set_pins(3'h0);
        wait_for(0, 8'h00, 45);
    endtask

    task automatic test_pickup();
        reg_write(OFF_PICKUP_BASE, 32'h0000000A);
        set_pins(3'h1);
        repeat (40) @(posedge mclk);
        #1;
        check("pickup early", 32'h0, 32'(inputState));
        wait_for(0, 8'h01, 60);
        set_pins(3'h0);
        wait_for(0, 8'h00, 45);
        // Each level lasts one full scan, so every revert is really sampled.
        set_pins(3'h1);
        repeat (20) @(posedge mclk);
        set_pins(3'h0);
        repeat (20) @(posedge mclk);
        set_pins(3'h1);
        repeat (66) @(posedge mclk);
        #1;
        check("restart", 32'h0, 32'(inputState));
        wait_for(0, 8'h01, 60);
        reg_write(OFF_PICKUP_BASE, 32'h00000000);
    endtask

    task automatic test_dropout();
        set_pins(3'h5);
        wait_for(0, 8'h05, 45);
        reg_write(OFF_DROPOUT_BASE, 32'h00000002);
        reg_write(OFF_DROPOUT_BASE + 8'h08, 32'h00000002);
        reg_write(OFF_INPUT_CFG, 32'h00000100);
        set_pins(3'h0);
        wait_for(0, 8'h01, 55);
        repeat (70) @(posedge mclk);
        #1;
        check("ac hold", 32'h1, 32'(inputState));
        wait_for(0, 8'h00, 100);
        reg_write(OFF_INPUT_CFG, 32'h00000000);
        reg_write(OFF_DROPOUT_BASE, 32'h00000000);
        reg_write(OFF_DROPOUT_BASE + 8'h08, 32'h00000000);
    endtask

    task automatic test_route();
        reg_write(OFF_RELAY_SW, 32'h00000010);
        reg_write(OFF_ROUTE_SEL, 32'h0000000D);
        reg_write(OFF_ROUTE_EN, 32'h00000003);
        wait_for(1, 8'h10, 25);
        set_pins(3'h2);
        wait_for(0, 8'h02, 45);
        check("relay lag", 32'h10, 32'(relayChannel));
        wait_for(1, 8'h11, 25);
        reg_read(OFF_STATUS);
        check("status relay", 32'h11, 32'(rd[20:16]));
        reg_write(OFF_ROUTE_EN, 32'h00000000);
        reg_write(OFF_RELAY_SW, 32'h00000000);
        set_pins(3'h0);
        wait_for(1, 8'h00, 25);
    endtask

    task automatic test_fault();
        set_health(1'b1, 1'b1);
        wait_for(2, 8'h00, 3);
        set_health(1'b1, 1'b0);
        wait_for(2, 8'h01, 3);
        set_health(1'b0, 1'b0);
        wait_for(2, 8'h00, 3);
        set_health(1'b1, 1'b0);
        wait_for(2, 8'h01, 3);
        reg_write(OFF_FAULT_CTRL, 32'h00000001);
        wait_for(2, 8'h00, 3);
        reg_read(OFF_STATUS);
        check("status fault", 32'h0, 32'(rd[24]));
        reg_write(OFF_FAULT_CTRL, 32'h00000000);
        wait_for(2, 8'h01, 3);
    endtask

    initial begin
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        test_defaults();
        test_polarity();
        test_pickup();
        test_dropout();
        test_route();
        test_fault();
        finish_test();
    end
endmodule
